/* File: aan_pkg.sv */
// Purpose: Shared constants and types for the attention notifier link
// Assumes: One clock, mclk at 100 MHz
// Notes: Notice frame fields follow the Set Device Bits layout
package aan_pkg;
  localparam logic [7:0] AAN_FIS_SDB = 8'ha1;
  localparam logic [7:0] AAN_FIS_REG_H2D = 8'h27;
  localparam logic [7:0] AAN_ZERO8 = 8'h00;
  localparam logic [2:0] AAN_ZERO3 = 3'h0;
  localparam int AAN_BIT_I = 6;
  localparam int AAN_BIT_N = 7;
  // Host-side APB register offsets
  localparam logic [11:0] AAN_OFF_CTRL = 12'h000;
  localparam logic [11:0] AAN_OFF_STAT = 12'h004;
  localparam logic [11:0] AAN_OFF_MASK = 12'h008;
  localparam logic [11:0] AAN_OFF_LAST = 12'h00c;
  localparam int AAN_CTRL_EN = 0;
  localparam int AAN_CTRL_ACK = 1;
  localparam int AAN_ST_SDB = 0;
  localparam int AAN_ST_NOTE = 1;
  localparam int AAN_ST_ENDONE = 2;
  localparam logic [2:0] AAN_ST_RST = 3'h0;
  localparam logic [1:0] AAN_ACT_NONE = 2'h0;
  localparam logic [1:0] AAN_ACT_EN = 2'h1;
  localparam logic [1:0] AAN_ACT_ACK = 2'h2;
  typedef enum logic [1:0] {
    AAN_IDLE = 2'b00,
    AAN_NOTIFY = 2'b01,
    AAN_CHECK = 2'b11
  } aan_state_type;
  // Device to host Set Device Bits frame
  typedef struct packed {
    logic [7:0] fis_type;
    logic [7:0] flags;
    logic [2:0] status_upper_part;
    logic [2:0] status_lower_part;
    logic [7:0] error;
    logic [31:0] reserved;
  } aan_sdb_type;
endpackage : aan_pkg

/* File: aan_link_if.sv */
// Purpose: Frame link between host controller and device notifier
// Assumes: Frames are single-cycle pulses with their payload
// Notes: Both ends run on mclk
`timescale 1ns/1ns
interface aan_link_if import aan_pkg::*; (
  input wire logic mclk
);
  logic sdb_valid;
  aan_sdb_type sdb;
  logic h2d_valid;
  logic [7:0] h2d_type;
  logic [7:0] h2d_feature;
  logic h2d_set_notify;
  modport device (
    input mclk, h2d_valid, h2d_type, h2d_feature, h2d_set_notify,
    output sdb_valid, sdb
  );
  modport host (
    input mclk, sdb_valid, sdb,
    output h2d_valid, h2d_type, h2d_feature, h2d_set_notify
  );
endinterface : aan_link_if

/* File: aan_sdb_builder.sv */
// Purpose: Registers a Set Device Bits frame for transmission
// Assumes: send is a one-cycle request
// Notes: Reserved fields are always zero
`timescale 1ns/1ns
module aan_sdb_builder import aan_pkg::*; (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic send,
  input wire logic intr_flag,
  input wire logic note_flag,
  input wire logic [2:0] stat_hi,
  input wire logic [2:0] stat_lo,
  input wire logic [7:0] err,
  output logic valid_ff,
  output aan_sdb_type frame_ff
);
  logic nxt_valid;
  aan_sdb_type nxt_frame;
  always_comb begin
    nxt_valid = send;
    nxt_frame = frame_ff;
    if (send) begin
      nxt_frame = '0;
      nxt_frame.fis_type = AAN_FIS_SDB;
      nxt_frame.flags[AAN_BIT_I] = intr_flag;
      nxt_frame.flags[AAN_BIT_N] = note_flag;
      nxt_frame.status_upper_part = stat_hi;
      nxt_frame.status_lower_part = stat_lo;
      nxt_frame.error = err;
    end
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      valid_ff <= 1'b0;
      frame_ff <= '0;
    end else begin
      valid_ff <= nxt_valid;
      frame_ff <= nxt_frame;
    end
  end
endmodule : aan_sdb_builder

/* File: aan_device.sv */
// Purpose: Device end: asynchronous attention notification
// Assumes: Command layer gives idle state and SDB permission as levels
// Notes: Error and status follow live register contents
`timescale 1ns/1ns
module aan_device import aan_pkg::*; (
  input wire logic mclk,
  input wire logic reset_n,
  aan_link_if.device link,
  input wire logic attention,
  input wire logic cmd_idle,
  input wire logic sdb_allowed,
  input wire logic other_sdb_req,
  input wire logic other_sdb_intr,
  input wire logic [2:0] status_upper_part,
  input wire logic [2:0] status_lower_part,
  input wire logic [7:0] error_reg,
  output logic enabled_ff,
  output logic notice_outstanding_ff,
  output logic busy_ff
);
  aan_state_type state_ff, nxt_state;
  logic nxt_enabled, nxt_outstanding, nxt_busy;
  logic pend_ff, nxt_pend;
  logic send, intr_flag, note_flag, h2d_reg;
  assign h2d_reg = link.h2d_valid && (link.h2d_type == AAN_FIS_REG_H2D);
  always_comb begin
    nxt_state = state_ff;
    nxt_enabled = enabled_ff;
    nxt_outstanding = notice_outstanding_ff;
    nxt_pend = pend_ff;
    send = 1'b0;
    intr_flag = 1'b0;
    note_flag = 1'b0;
    if (h2d_reg && link.h2d_set_notify) begin
      nxt_enabled = link.h2d_feature[0];
    end
    if (attention && enabled_ff && !notice_outstanding_ff) begin
      nxt_pend = 1'b1;
    end
    if (attention && notice_outstanding_ff) begin
      nxt_pend = pend_ff;
    end
    case (state_ff)
      AAN_IDLE: begin
        if (pend_ff && enabled_ff && cmd_idle && sdb_allowed) begin
          nxt_state = AAN_NOTIFY;
        end else if (other_sdb_req && sdb_allowed) begin
          send = 1'b1;
          intr_flag = other_sdb_intr;
          note_flag = 1'b0;
        end
      end
      AAN_NOTIFY: begin
        send = 1'b1;
        intr_flag = 1'b1;
        note_flag = enabled_ff;
        nxt_outstanding = enabled_ff;
        nxt_pend = 1'b0;
        nxt_state = AAN_IDLE;
      end
      default: begin
        nxt_state = AAN_IDLE;
      end
    endcase
    if (h2d_reg && (state_ff != AAN_NOTIFY)) begin
      nxt_outstanding = 1'b0;
    end
    if (!nxt_enabled) begin
      nxt_pend = 1'b0;
    end
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= AAN_IDLE;
      enabled_ff <= 1'b0;
      notice_outstanding_ff <= 1'b0;
      pend_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      enabled_ff <= nxt_enabled;
      notice_outstanding_ff <= nxt_outstanding;
      pend_ff <= nxt_pend;
      busy_ff <= nxt_busy;
    end
  end
  assign nxt_busy = (nxt_state != AAN_IDLE);
  aan_sdb_builder u_sdb (
    .mclk(mclk),
    .reset_n(reset_n),
    .send(send),
    .intr_flag(intr_flag),
    .note_flag(note_flag),
    .stat_hi(status_upper_part),
    .stat_lo(status_lower_part),
    .err(error_reg),
    .valid_ff(link.sdb_valid),
    .frame_ff(link.sdb)
  );
endmodule : aan_device

/* File: aan_host.sv */
// Purpose: Host end: APB-controlled notice receiver
// Assumes: APB slave, one wait state on every access
// Notes: Status clears on read; set wins over clear
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ns
module aan_host import aan_pkg::*; (
  input wire logic mclk,
  input wire logic reset_n,
  aan_link_if.host link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq_ff
);
  logic [2:0] stat_ff, nxt_stat, mask_ff, nxt_mask, set_ev;
  logic [1:0] act_ff, nxt_act;
  logic en_ff, nxt_en;
  logic host_notice_register_ff, nxt_hnr;
  logic [31:0] rd_ff, nxt_rd;
  logic [7:0] last_ff, nxt_last;
  logic rdy_ff, nxt_rdy, err_ff, nxt_err;
  logic wr, rd, hit, load;
  // Read data is loaded in the first access cycle and stands with pready in the second
  assign load = psel && penable && !rdy_ff;
  assign wr = psel && penable && rdy_ff && pwrite;
  assign rd = psel && penable && rdy_ff && !pwrite;
  assign hit = (paddr == AAN_OFF_CTRL) || (paddr == AAN_OFF_STAT) ||
               (paddr == AAN_OFF_MASK) || (paddr == AAN_OFF_LAST);
  assign pready = rdy_ff;
  assign pslverr = err_ff;
  assign prdata = rd_ff;
  always_comb begin
    set_ev = '0;
    set_ev[AAN_ST_SDB] = link.sdb_valid;
    set_ev[AAN_ST_NOTE] = link.sdb_valid && link.sdb.flags[AAN_BIT_N];
    set_ev[AAN_ST_ENDONE] = (act_ff == AAN_ACT_EN);
    nxt_stat = stat_ff;
    nxt_mask = mask_ff;
    nxt_en = en_ff;
    nxt_act = AAN_ACT_NONE;
    nxt_hnr = host_notice_register_ff;
    nxt_last = last_ff;
    nxt_rd = rd_ff;
    nxt_rdy = load;
    nxt_err = load && !hit;
    if (link.sdb_valid) begin
      nxt_last = link.sdb.error;
    end
    if (wr && paddr == AAN_OFF_CTRL) begin
      if (pwdata[AAN_CTRL_EN] != en_ff) begin
        nxt_act = AAN_ACT_EN;
      end else if (pwdata[AAN_CTRL_ACK]) begin
        nxt_act = AAN_ACT_ACK;
      end
      nxt_en = pwdata[AAN_CTRL_EN];
    end else if (wr && paddr == AAN_OFF_MASK) begin
      nxt_mask = pwdata[2:0];
    end
    if (load && !pwrite) begin
      if (paddr == AAN_OFF_CTRL) begin
        nxt_rd = {29'h0, host_notice_register_ff, 1'b0, en_ff};
      end else if (paddr == AAN_OFF_STAT) begin
        nxt_rd = {29'h0, stat_ff};
      end else if (paddr == AAN_OFF_MASK) begin
        nxt_rd = {29'h0, mask_ff};
      end else if (paddr == AAN_OFF_LAST) begin
        nxt_rd = {24'h0, last_ff};
      end else begin
        nxt_rd = '0;
      end
    end
    // Clear only the bits that were reported, so a late event is kept
    if (rd && paddr == AAN_OFF_STAT) begin
      nxt_stat = stat_ff & ~rd_ff[2:0];
      nxt_hnr = host_notice_register_ff && !rd_ff[AAN_ST_NOTE];
    end
    nxt_stat = nxt_stat | set_ev;
    if (set_ev[AAN_ST_NOTE]) begin
      nxt_hnr = 1'b1;
    end
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      stat_ff <= AAN_ST_RST;
      mask_ff <= AAN_ST_RST;
      en_ff <= 1'b0;
      act_ff <= AAN_ACT_NONE;
      host_notice_register_ff <= 1'b0;
      last_ff <= AAN_ZERO8;
      rd_ff <= '0;
      rdy_ff <= 1'b0;
      err_ff <= 1'b0;
      irq_ff <= 1'b0;
      link.h2d_valid <= 1'b0;
      link.h2d_type <= AAN_ZERO8;
      link.h2d_feature <= AAN_ZERO8;
      link.h2d_set_notify <= 1'b0;
    end else begin
      stat_ff <= nxt_stat;
      mask_ff <= nxt_mask;
      en_ff <= nxt_en;
      act_ff <= nxt_act;
      host_notice_register_ff <= nxt_hnr;
      last_ff <= nxt_last;
      rd_ff <= nxt_rd;
      rdy_ff <= nxt_rdy;
      err_ff <= nxt_err;
      irq_ff <= |(nxt_stat & nxt_mask);
      link.h2d_valid <= (nxt_act != AAN_ACT_NONE);
      link.h2d_type <= AAN_FIS_REG_H2D;
      link.h2d_feature <= {7'h0, nxt_en};
      link.h2d_set_notify <= (nxt_act == AAN_ACT_EN);
    end
  end
endmodule : aan_host

/* File: aan_assertions.sv */
// Purpose: Link checks for the notifier pair
// Assumes: One clock, reset_n async active low
// Notes: Enable and outstanding are tracked from frames
`timescale 1ns/1ns
module aan_assertions import aan_pkg::*; (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic sdb_valid,
  input wire aan_sdb_type sdb,
  input wire logic h2d_valid,
  input wire logic [7:0] h2d_type,
  input wire logic [7:0] h2d_feature,
  input wire logic h2d_set_notify
);
  logic en_ff;
  logic out_ff;
  logic nxt_en;
  logic nxt_out;
  logic note;
  assign note = sdb_valid && sdb.flags[AAN_BIT_N];
  always_comb begin
    nxt_en = en_ff;
    nxt_out = out_ff;
    if (h2d_valid && h2d_set_notify) begin
      nxt_en = h2d_feature[0];
    end
    if (h2d_valid && h2d_type == AAN_FIS_REG_H2D) begin
      nxt_out = 1'b0;
    end
    if (note) begin
      nxt_out = 1'b1;
    end
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      en_ff <= 1'b0;
      out_ff <= 1'b0;
    end else begin
      en_ff <= nxt_en;
      out_ff <= nxt_out;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  property p_off; note |-> en_ff; endproperty
  a_off: assert property (p_off) else $error("notice while disabled");
  property p_flags; note |-> sdb.flags[AAN_BIT_I] && sdb.fis_type == AAN_FIS_SDB; endproperty
  a_flags: assert property (p_flags) else $error("notice frame malformed");
  property p_resv; note |-> sdb.reserved == 32'h0; endproperty
  a_resv: assert property (p_resv) else $error("reserved not zero");
  property p_supp; note |-> !out_ff; endproperty
  a_supp: assert property (p_supp) else $error("notice while outstanding");
  property p_idle; note |=> !note [*2]; endproperty
  a_idle: assert property (p_idle) else $error("notice repeated");
  property p_rst; $rose(reset_n) |-> !sdb_valid && !h2d_valid; endproperty
  a_rst: assert property (p_rst) else $error("frame at reset exit");
  property p_ack; h2d_valid |-> h2d_type == AAN_FIS_REG_H2D; endproperty
  a_ack: assert property (p_ack) else $error("host frame type wrong");
  property p_h2d; $rose(h2d_valid) |=> $fell(h2d_valid); endproperty
  a_h2d: assert property (p_h2d) else $error("host frame not a pulse");
endmodule : aan_assertions

/* File: async_attention_notifier_tb.sv */
// Purpose: Bench for device and host notifier ends
// Assumes: APB slave answers after one wait state
// Notes: Notices go row by row, then special cases
`timescale 1ns/1ns
module async_attention_notifier_tb import aan_pkg::*;;
  typedef struct packed {logic [2:0] hi; logic [2:0] lo; logic [7:0] er;} aan_row_type;
  aan_row_type rows [3] = '{'{3'h5, 3'h2, 8'h41}, '{3'h7, 3'h0, 8'h00}, '{3'h0, 3'h7, 8'hff}};
  logic mclk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, attention = 0;
  logic cmd_idle = 1, sdb_allowed = 1, oreq = 0, ointr = 0, perr, got, bsy;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, rd;
  logic [2:0] hi = 3'h0, lo = 3'h0;
  logic [7:0] er = 8'h00;
  logic en, outst, busy, pready, pslverr, irq;
  logic [31:0] prdata;
  aan_sdb_type fr;
  int num_errors = 0, n_checks = 0, cyc = 0;
  initial forever #5 mclk = ~mclk;
  aan_link_if u_aan_link_if (.mclk(mclk));
  aan_device u_aan_device (.mclk(mclk), .reset_n(reset_n), .link(u_aan_link_if),
    .attention(attention), .cmd_idle(cmd_idle), .sdb_allowed(sdb_allowed),
    .other_sdb_req(oreq), .other_sdb_intr(ointr), .status_upper_part(hi),
    .status_lower_part(lo), .error_reg(er), .enabled_ff(en),
    .notice_outstanding_ff(outst), .busy_ff(busy));
  aan_host u_aan_host (.mclk(mclk), .reset_n(reset_n), .link(u_aan_link_if), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq_ff(irq));
  aan_assertions u_aan_assertions (.mclk(mclk), .reset_n(reset_n),
    .sdb_valid(u_aan_link_if.sdb_valid), .sdb(u_aan_link_if.sdb),
    .h2d_valid(u_aan_link_if.h2d_valid), .h2d_type(u_aan_link_if.h2d_type),
    .h2d_feature(u_aan_link_if.h2d_feature), .h2d_set_notify(u_aan_link_if.h2d_set_notify));
  task automatic results();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      results();
    end
  end
  task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge mclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    // Request stands until pready is seen high at a rising edge
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    perr = pslverr;
    rd = prdata;
    psel <= 0;
    penable <= 0;
  endtask : apb
  // Watches ten cycles and keeps the first frame seen
  task automatic grab();
    got = 0;
    bsy = 0;
    repeat (10) begin
      @(negedge mclk);
      if (busy === 1'b1) bsy = 1;
      if (u_aan_link_if.sdb_valid === 1'b1 && !got) begin
        got = 1;
        fr = u_aan_link_if.sdb;
      end
    end
  endtask : grab
  task automatic note();
    @(posedge mclk);
    attention <= 1;
    @(posedge mclk);
    attention <= 0;
    grab();
  endtask : note
  task automatic plain();
    @(posedge mclk);
    oreq <= 1;
    ointr <= 1;
    @(posedge mclk);
    oreq <= 0;
    grab();
  endtask : plain
  initial begin
    repeat (12) @(posedge mclk);
    reset_n <= 1;
    apb(1, AAN_OFF_MASK, 32'h7);
    apb(1, AAN_OFF_CTRL, 32'h1);
    repeat (2) @(posedge mclk);
    chk("enabled", en, 1);
    chk("irq", irq, 1);
    apb(0, AAN_OFF_STAT, 32'h0);
    chk("stat", rd[2:0], 3'h4);
    foreach (rows[i]) begin
      hi <= rows[i].hi;
      lo <= rows[i].lo;
      er <= rows[i].er;
      note();
      chk("note", got, 1);
      chk("busy", bsy, 1);
      chk("flags", fr.flags[7:6], 2'h3);
      chk("fields", {fr.status_upper_part, fr.status_lower_part, fr.error}, rows[i]);
      chk("resv", fr.reserved, 32'h0);
      chk("outst", outst, 1);
      apb(0, AAN_OFF_STAT, 32'h0);
      chk("stat", rd[1:0], 2'h3);
      apb(0, AAN_OFF_LAST, 32'h0);
      chk("last", rd[7:0], rows[i].er);
      apb(1, AAN_OFF_CTRL, 32'h3);
      repeat (2) @(posedge mclk);
      chk("ack", outst, 0);
    end
    $display("rows done");
    note();
    note();
    chk("suppress", got, 0);
    apb(1, AAN_OFF_CTRL, 32'h3);
    note();
    chk("renote", got, 1);
    apb(1, AAN_OFF_CTRL, 32'h3);
    $display("suppress done");
    @(posedge mclk);
    sdb_allowed <= 0;
    attention <= 1;
    grab();
    chk("perm", got, 0);
    chk("perm busy", bsy, 0);
    @(posedge mclk);
    cmd_idle <= 0;
    sdb_allowed <= 1;
    grab();
    chk("idle", got, 0);
    @(posedge mclk);
    cmd_idle <= 1;
    grab();
    chk("late", got, 1);
    @(posedge mclk);
    attention <= 0;
    apb(1, AAN_OFF_CTRL, 32'h3);
    apb(0, AAN_OFF_STAT, 32'h0);
    $display("permit done");
    plain();
    chk("plain", fr.flags[7:6], 2'h1);
    chk("irq", irq, 1);
    apb(0, AAN_OFF_STAT, 32'h0);
    chk("stat", rd[2:0], 3'h1);
    @(posedge mclk);
    chk("clr", irq, 0);
    apb(1, AAN_OFF_MASK, 32'h0);
    plain();
    chk("mask", irq, 0);
    apb(0, 12'h010, 32'h0);
    chk("pslverr", perr, 1);
    $display("host done");
    reset_n <= 0;
    repeat (3) @(posedge mclk);
    chk("rst en", en, 0);
    chk("rst out", outst, 0);
    reset_n <= 1;
    note();
    chk("off", got, 0);
    $display("reset done");
    results();
  end
endmodule : async_attention_notifier_tb
